// ===== rtl/offset_limiter.sv
// Current offset window, schedule update and display control for the weld controller.
`timescale 1ns/1ps
module offset_limiter
  import offset_limiter_pkg::*;
(
  input  wire logic                                      ref_clk,
  input  wire logic                                      resetn,
  input  wire logic                                      program_mode,
  input  wire logic                                      code_write,
  input  wire logic [offset_limiter_pkg::CODE_W-1:0]     code_value,
  input  wire logic                                      cc_write,
  input  wire logic [offset_limiter_pkg::CODE_W-1:0]     cc_value,
  input  wire logic                                      turns_write,
  input  wire logic [7:0]                                turns_value,
  input  wire logic                                      range_write,
  input  wire logic [offset_limiter_pkg::CUR_W-1:0]      range_value,
  input  wire logic                                      kiloamp_units,
  input  wire logic [offset_limiter_pkg::SCHED_W-1:0]    shown_schedule,
  input  wire logic                                      base_write,
  input  wire logic [offset_limiter_pkg::CUR_W-1:0]      base_value,
  input  wire logic                                      data_up,
  input  wire logic                                      data_down,
  input  wire logic                                      enter_press,
  output logic [offset_limiter_pkg::CODE_W-1:0]          offset_code,
  output logic [offset_limiter_pkg::CODE_W-1:0]          cc_mode,
  output logic [7:0]                                     turns_ratio,
  output logic [offset_limiter_pkg::CUR_W-1:0]           range_setting,
  output logic [offset_limiter_pkg::GAIN_W-1:0]          amp_gain,
  output logic                                           percent_of_max,
  output logic                                           cc_compensate,
  output logic                                           cc_monitor,
  output logic [offset_limiter_pkg::CUR_W-1:0]           shown_current,
  output logic [offset_limiter_pkg::CUR_W-1:0]           display_value,
  output offset_limiter_pkg::prefix_type                 display_prefix,
  output logic                                           display_offset_phase,
  output logic                                           busy
);
  import offset_limiter_pkg::*;

  // ---------------------------------------------------------------
  // Stored settings and schedule currents
  // ---------------------------------------------------------------
  logic [CUR_W-1:0]   base_cur [NUM_SCHEDULES];
  logic [CUR_W-1:0]   oper_cur [NUM_SCHEDULES];
  logic [CUR_W-1:0]   pending;
  logic               pending_valid;
  logic [FLASH_W-1:0] flash_count;
  logic signed [CUR_W+1:0] sweep_delta;
  apply_state_type    state;
  apply_state_type    next_state;
  logic [SCHED_W-1:0] sweep_index;

  // The range calculator is pure logic; every limit it returns settles within the cycle.
  limit_if lim ();

  range_calc u_range_calc
  (
    .lim (lim)
  );

  assign lim.cc_mode   = cc_mode;
  assign lim.turns     = turns_ratio;
  // The stored range sets gain, full scale and the percent-of-max test; the live
  // value is looked at only in the cycle in which it is written.
  assign lim.range_req = (program_mode && range_write) ? range_value : range_setting;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire code_legal  = code_value <= OFFSET_ALL_HI;
  wire mode_single = offset_code >= OFFSET_SINGLE_LO && offset_code <= OFFSET_SINGLE_HI;
  wire mode_all    = offset_code >= OFFSET_ALL_LO && offset_code <= OFFSET_ALL_HI;
  // Codes 00 and 20 both leave offset_on low, so operate-mode presses are lost.
  wire offset_on   = mode_single || mode_all;
  wire [CODE_W-1:0] pct = mode_all ? CODE_W'(offset_code - OFFSET_ALL_OFF)
                        : mode_single ? offset_code : '0;

  // ---------------------------------------------------------------
  // Constant-current decode
  // ---------------------------------------------------------------
  wire cc_primary  = cc_mode >= CC_AUTO_PRI_COMP && cc_mode <= CC_PRESET_HI;
  wire cc_second   = cc_mode >= CC_AUTO_SEC_COMP && cc_mode <= CC_SEC_MON;
  wire cc_active   = cc_primary || cc_second;
  wire kiloamp     = cc_active && kiloamp_units && !lim.percent_of_max;

  // ---------------------------------------------------------------
  // Offset window for the displayed schedule
  // ---------------------------------------------------------------
  wire [CUR_W-1:0]   base_shown  = base_cur[shown_schedule];
  wire [CUR_W-1:0]   oper_shown  = oper_cur[shown_schedule];
  // In kA mode the offset is a percent of full-scale range; otherwise of 100 %.
  wire [CUR_W-1:0]   full_scale  = kiloamp ? lim.range_ok : PCT_FULL;
  wire [CUR_W+CODE_W-1:0] span_p = (CUR_W+CODE_W)'(full_scale) * (CUR_W+CODE_W)'(pct);
  // The span rounds down, so the window never reaches past the set offset.
  wire [CUR_W-1:0]   span        = CUR_W'(span_p / (CUR_W+CODE_W)'(PCT_FULL));
  wire [CUR_W:0]     win_hi      = (CUR_W+1)'(base_shown) + (CUR_W+1)'(span);
  wire [CUR_W-1:0]   win_lo      = (base_shown > span) ? CUR_W'(base_shown - span) : '0;
  wire [CUR_W-1:0]   cur_src     = pending_valid ? pending : oper_shown;
  wire [CUR_W:0]     step_up     = (CUR_W+1)'(cur_src) + (CUR_W+1)'(1);
  wire [CUR_W:0]     step_raw    = data_up ? step_up
                                 : (cur_src == '0 ? '0 : (CUR_W+1)'(cur_src) - (CUR_W+1)'(1));
  wire [CUR_W-1:0]   step_sat    = (step_raw > win_hi) ? CUR_W'(win_hi)
                                 : (step_raw < (CUR_W+1)'(win_lo)) ? win_lo
                                 : CUR_W'(step_raw);
  wire               press       = !program_mode && offset_on && (data_up ^ data_down);
  wire               commit_now  = press && !kiloamp;
  wire               commit_ent  = !program_mode && offset_on && kiloamp && enter_press
                                && pending_valid;
  wire               commit      = (commit_now || commit_ent) && state == ST_IDLE;
  wire [CUR_W-1:0]   commit_val  = commit_now ? step_sat : pending;
  wire signed [CUR_W+1:0] delta  = $signed((CUR_W+2)'(commit_val)) - $signed((CUR_W+2)'(oper_shown));

  // ---------------------------------------------------------------
  // Apply sequencer: one write, or a sweep over all schedules
  // ---------------------------------------------------------------
  // A commit that comes while busy is dropped; the panel waits for busy to fall.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:  next_state = commit ? (mode_all ? ST_SWEEP : ST_WRITE) : ST_IDLE;
      ST_WRITE: next_state = ST_IDLE;
      ST_SWEEP: next_state = (sweep_index == SCHED_W'(NUM_SCHEDULES - 1)) ? ST_IDLE : ST_SWEEP;
      default:  next_state = ST_IDLE;
    endcase
  end

  // Busy is combinational so the panel sees it in the cycle the sequencer leaves idle.
  assign busy = state != ST_IDLE;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state       <= ST_IDLE;
      sweep_index <= '0;
      sweep_delta <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE)
      begin
        sweep_index <= '0;
        sweep_delta <= delta;
      end
      else
        sweep_index <= SCHED_W'(sweep_index + 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // Settings held for the extended menu
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      offset_code   <= OFFSET_DISABLED;
      cc_mode       <= CC_OFF;
      turns_ratio   <= TURNS_MIN;
      range_setting <= BASE_RESET;
    end
    else
    begin
      // Writes count only in program mode; an offset code beyond the table is dropped whole.
      if (program_mode && code_write && code_legal)
        offset_code <= code_value;
      if (program_mode && cc_write)
        cc_mode <= cc_value;
      if (program_mode && turns_write)
        turns_ratio <= (turns_value < TURNS_MIN) ? TURNS_MIN : turns_value;
      if (program_mode && range_write)
        range_setting <= lim.range_ok;
    end
  end

  // ---------------------------------------------------------------
  // Pending kA value awaiting enter
  // ---------------------------------------------------------------
  // Leaving operate mode drops an unconfirmed value, so a stale entry is never
  // committed by a later enter.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pending       <= BASE_RESET;
      pending_valid <= 1'b0;
    end
    else if (press && kiloamp)
    begin
      pending       <= step_sat;
      pending_valid <= 1'b1;
    end
    else if (commit || program_mode)
      pending_valid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Per-schedule weld current storage; nothing else is held here
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_SCHEDULES; i++)
  begin : g_sched
    // A sweep may carry a schedule below zero; it is floored there, not wrapped.
    wire signed [CUR_W+1:0] moved = $signed((CUR_W+2)'(oper_cur[i])) + sweep_delta;
    wire [CUR_W-1:0] moved_sat = (moved < 0) ? '0 : CUR_W'(moved);
    // Base writes win over operate-mode changes; program mode holds presses off anyway.
    wire base_hit  = program_mode && base_write && shown_schedule == SCHED_W'(i);
    wire one_hit   = state == ST_IDLE && commit && !mode_all && shown_schedule == SCHED_W'(i);
    wire sweep_hit = state == ST_SWEEP && sweep_index == SCHED_W'(i);
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        base_cur[i] <= BASE_RESET;
        oper_cur[i] <= BASE_RESET;
      end
      else if (base_hit)
      begin
        base_cur[i] <= base_value;
        oper_cur[i] <= base_value;
      end
      else if (one_hit)
        oper_cur[i] <= commit_val;
      else if (sweep_hit)
        oper_cur[i] <= moved_sat;
    end
  end

  // ---------------------------------------------------------------
  // Display alternation and outputs
  // ---------------------------------------------------------------
  // The alternation counter runs only while there are two values to show.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_count          <= '0;
      display_offset_phase <= 1'b0;
    end
    else if (!(program_mode && offset_on))
    begin
      flash_count          <= '0;
      display_offset_phase <= 1'b0;
    end
    else if (flash_count == FLASH_W'(FLASH_CYCLES - 1))
    begin
      flash_count          <= '0;
      display_offset_phase <= !display_offset_phase;
    end
    else
      flash_count <= FLASH_W'(flash_count + 1'b1);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shown_current  <= BASE_RESET;
      display_value  <= BASE_RESET;
      display_prefix <= PREFIX_NONE;
    end
    else
    begin
      shown_current  <= oper_shown;
      display_value  <= (program_mode && !display_offset_phase) ? base_shown
                      : (pending_valid ? pending : oper_shown);
      display_prefix <= mode_single ? PREFIX_SINGLE : mode_all ? PREFIX_ALL : PREFIX_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Constant-current status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      amp_gain       <= '0;
      percent_of_max <= 1'b0;
      cc_compensate  <= 1'b0;
      cc_monitor     <= 1'b0;
    end
    else
    begin
      amp_gain       <= lim.gain;
      percent_of_max <= lim.percent_of_max && cc_active;
      cc_compensate  <= cc_active && !cc_mode[0];
      cc_monitor     <= cc_active;
    end
  end

endmodule

// ===== include/offset_limiter_pkg.sv
// Constants and types shared by the current offset and range limiter.
package offset_limiter_pkg;

  // ---------------------------------------------------------------
  // Schedules and value widths
  // ---------------------------------------------------------------
  localparam int          NUM_SCHEDULES    = 50;
  localparam int          SCHED_W          = 6;
  localparam int          CUR_W            = 14;   // Percent or kA x100
  localparam int          CODE_W           = 7;
  localparam logic [6:0]  OFFSET_DISABLED  = 7'h00;
  localparam logic [6:0]  OFFSET_SINGLE_LO = 7'h01;
  localparam logic [6:0]  OFFSET_SINGLE_HI = 7'h13;
  localparam logic [6:0]  OFFSET_ALL_OFF   = 7'h14;
  localparam logic [6:0]  OFFSET_ALL_LO    = 7'h15;
  localparam logic [6:0]  OFFSET_ALL_HI    = 7'h27;

  // ---------------------------------------------------------------
  // Constant-current mode codes
  // ---------------------------------------------------------------
  localparam logic [6:0]  CC_OFF           = 7'h00;
  localparam logic [6:0]  CC_AUTO_PRI_COMP = 7'h0A;
  localparam logic [6:0]  CC_AUTO_PRI_MON  = 7'h0B;
  localparam logic [6:0]  CC_PRESET_LO     = 7'h0C;
  localparam logic [6:0]  CC_PRESET_HI     = 7'h13;
  localparam logic [6:0]  CC_AUTO_SEC_COMP = 7'h1E;
  localparam logic [6:0]  CC_AUTO_SEC_MON  = 7'h1F;
  localparam logic [6:0]  CC_SEC_COMP      = 7'h20;
  localparam logic [6:0]  CC_SEC_MON       = 7'h21;

  // ---------------------------------------------------------------
  // Range limits in units of 0.01 kA
  // ---------------------------------------------------------------
  localparam logic [13:0] RANGE_MAX        = 14'h270F;  // 99.99 kA
  localparam logic [13:0] RANGE_MIN        = 14'h00C8;  // 2 kA
  localparam logic [13:0] RANGE_PERCENT    = 14'h0063;  // 0.99
  localparam logic [7:0]  TURNS_MIN        = 8'h0A;
  localparam logic [7:0]  TURNS_MAX        = 8'hFF;
  localparam logic [13:0] PCT_FULL         = 14'h0064;  // 100 percent
  localparam logic [13:0] BASE_RESET       = 14'h0000;
  localparam int          GAIN_W           = 2;
  localparam logic [13:0] GAIN_STEP0       = 14'h03E8;  // 10 kA
  localparam logic [13:0] GAIN_STEP1       = 14'h07D0;  // 20 kA
  localparam logic [13:0] GAIN_STEP2       = 14'h1388;  // 50 kA

  // ---------------------------------------------------------------
  // Display
  // ---------------------------------------------------------------
  localparam time         FLASH_PERIOD_NS  = 500_000_000;
  localparam time         CLOCK_PERIOD_NS  = 5;
  localparam int          FLASH_CYCLES     = int'(FLASH_PERIOD_NS / CLOCK_PERIOD_NS);
  localparam int          FLASH_W          = 27;

  typedef enum logic [1:0]
  {
    PREFIX_NONE   = 2'h0,
    PREFIX_SINGLE = 2'h1,
    PREFIX_ALL    = 2'h2
  } prefix_type;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_SWEEP = 3'b100
  } apply_state_type;

endpackage

// ===== include/limit_if.sv
// Interface carrying the range-limit query between the limiter and its range calculator.
`timescale 1ns/1ps
interface limit_if;
  import offset_limiter_pkg::*;
  logic [CODE_W-1:0] cc_mode;
  logic [7:0]        turns;
  logic [CUR_W-1:0]  range_req;
  logic [CUR_W-1:0]  range_ok;
  logic [GAIN_W-1:0] gain;
  logic              percent_of_max;

  modport limiter (output cc_mode, output turns, output range_req,
                   input range_ok, input gain, input percent_of_max);
  modport calc (input cc_mode, input turns, input range_req,
                output range_ok, output gain, output percent_of_max);
endinterface

// ===== rtl/range_calc.sv
// Range limits by constant-current mode, amplifier gain and percent-of-max flag.
`timescale 1ns/1ps
module range_calc
  import offset_limiter_pkg::*;
(
  limit_if.calc lim
);

  wire              is_auto;
  wire              is_preset;
  wire              is_sec;
  wire [7:0]        turns_ok;
  wire [1:0]        pair;
  wire [15:0]       tr_x100;
  wire [17:0]       pre_max;
  wire [CUR_W-1:0]  max_val;
  wire [CUR_W-1:0]  min_val;
  wire [CUR_W-1:0]  clamped;

  assign is_auto   = lim.cc_mode == CC_AUTO_PRI_COMP || lim.cc_mode == CC_AUTO_PRI_MON
                  || lim.cc_mode == CC_AUTO_SEC_COMP || lim.cc_mode == CC_AUTO_SEC_MON;
  assign is_preset = lim.cc_mode >= CC_PRESET_LO && lim.cc_mode <= CC_PRESET_HI;
  assign is_sec    = lim.cc_mode == CC_SEC_COMP || lim.cc_mode == CC_SEC_MON;
  assign turns_ok  = (lim.turns < TURNS_MIN) ? TURNS_MIN : lim.turns;
  assign pair      = 2'(lim.cc_mode - CC_PRESET_LO >> 1);
  assign tr_x100   = 16'(turns_ok) * 16'h0064;
  // Sensor pairs scale turns ratio by 0.2, 0.5, 1 and 2 kA per turn.
  assign pre_max   = (pair == 2'h0) ? 18'(tr_x100 / 16'h0005)
                   : (pair == 2'h1) ? 18'(tr_x100 >> 1)
                   : (pair == 2'h2) ? 18'(tr_x100)
                   : 18'(tr_x100) << 1;
  assign max_val   = (is_preset && pre_max < 18'(RANGE_MAX)) ? pre_max[CUR_W-1:0] : RANGE_MAX;
  assign min_val   = (is_preset || is_sec) ? RANGE_MIN : BASE_RESET;
  assign clamped   = (lim.range_req > max_val) ? max_val
                   : (lim.range_req < min_val) ? min_val : lim.range_req;
  assign lim.range_ok       = (lim.cc_mode == CC_OFF) ? BASE_RESET : clamped;
  assign lim.percent_of_max = (lim.cc_mode == CC_AUTO_PRI_COMP || lim.cc_mode == CC_AUTO_SEC_COMP)
                            && lim.range_req == RANGE_PERCENT;
  assign lim.gain = (lim.range_ok <= GAIN_STEP0) ? 2'h0
                  : (lim.range_ok <= GAIN_STEP1) ? 2'h1
                  : (lim.range_ok <= GAIN_STEP2) ? 2'h2 : 2'h3;

  wire unused_auto = is_auto;

endmodule

// ===== bench/offset_limiter_asserts.sv
// Port-level assertions for the current offset limiter.
`timescale 1ns/1ps
module offset_limiter_asserts
  import offset_limiter_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              program_mode,
  input wire logic              code_write,
  input wire logic [CODE_W-1:0] code_value,
  input wire logic              cc_write,
  input wire logic              range_write,
  input wire logic [CODE_W-1:0] offset_code,
  input wire logic [CODE_W-1:0] cc_mode,
  input wire logic [7:0]        turns_ratio,
  input wire logic [CUR_W-1:0]  range_setting,
  input wire prefix_type        display_prefix,
  input wire logic              cc_compensate,
  input wire logic              cc_monitor
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_code_refused:
    assert property (code_write && code_value > OFFSET_ALL_HI |=> $stable(offset_code))
    else $error("Offset code changed on a refused code");
  chk_code_store:
    assert property (program_mode && code_write && code_value <= OFFSET_ALL_HI |=> offset_code == $past(code_value))
    else $error("Offset code not stored");
  chk_prefix_single:
    assert property ((offset_code inside {[OFFSET_SINGLE_LO:OFFSET_SINGLE_HI]}) [*2] |-> display_prefix == PREFIX_SINGLE)
    else $error("Single marker missing");
  chk_prefix_all:
    assert property ((offset_code inside {[OFFSET_ALL_LO:OFFSET_ALL_HI]}) [*2] |-> display_prefix == PREFIX_ALL)
    else $error("All marker missing");
  chk_cc_parity:
    assert property ((cc_mode != CC_OFF) [*2] |-> cc_monitor && cc_compensate == !$past(cc_mode[0]))
    else $error("Compensation flags do not follow mode code");
  chk_turns_floor:
    assert property (turns_ratio >= TURNS_MIN)
    else $error("Turns ratio below floor");
  chk_range_cap:
    assert property (range_setting <= RANGE_MAX)
    else $error("Range above maximum");
  chk_range_off:
    assert property (program_mode && range_write && !cc_write && cc_mode == CC_OFF |=> range_setting == '0)
    else $error("Range stored without constant current");
endmodule
bind offset_limiter offset_limiter_asserts u_asserts (.ref_clk, .resetn, .program_mode, .code_write, .code_value,
  .cc_write, .range_write, .offset_code, .cc_mode, .turns_ratio, .range_setting, .display_prefix, .cc_compensate,
  .cc_monitor);

// ===== bench/front_panel_model.sv
// Front-panel model that turns a press request into spaced one-cycle data button pulses.
`timescale 1ns/1ps
module front_panel_model
(
  input  wire logic       ref_clk,
  input  wire logic       busy,
  input  wire logic       start,
  input  wire logic       press_dir,
  input  wire logic [7:0] press_count,
  output logic            data_up = 1'h0,
  output logic            data_down = 1'h0,
  output logic            idle
);
  logic [7:0] left = 8'h0;
  logic [1:0] gap = 2'h0;
  logic       fire;
  // A gap of three cycles lets busy rise before the next press is considered.
  assign idle = left == 8'h0 && gap == 2'h0 && !busy;
  assign fire = !start && gap == 2'h0 && left != 8'h0 && !busy;
  always @(posedge ref_clk)
  begin
    data_up <= fire && press_dir;
    data_down <= fire && !press_dir;
    if (start)
      left <= press_count;
    else if (gap != 2'h0)
      gap <= gap - 2'h1;
    else if (fire)
    begin
      left <= left - 8'h1;
      gap <= 2'h3;
    end
  end
endmodule

// ===== bench/testbench.sv
// Self-checking testbench for the current offset limiter.
`timescale 1ns/1ps
module testbench;
  import offset_limiter_pkg::*;
  logic               ref_clk = '0, resetn = '0, program_mode = '1, kiloamp_units = '0, enter_press = '0;
  logic               code_write = '0, cc_write = '0, turns_write = '0, range_write = '0, base_write = '0;
  logic               start = '0, press_dir = '0, data_up, data_down, idle, busy, percent_of_max;
  logic               cc_compensate, cc_monitor, display_offset_phase;
  logic [CODE_W-1:0]  code_value = '0, cc_value = '0, offset_code, cc_mode;
  logic [7:0]         turns_value = '0, press_count = '0, turns_ratio;
  logic [CUR_W-1:0]   range_value = '0, base_value = '0, range_setting, shown_current, display_value;
  logic [SCHED_W-1:0] shown_schedule = '0;
  logic [GAIN_W-1:0]  amp_gain;
  prefix_type         display_prefix;
  int                 failures = 0;
  int                 compares = 0;
  offset_limiter u_dut (.ref_clk, .resetn, .program_mode, .code_write, .code_value, .cc_write, .cc_value,
    .turns_write, .turns_value, .range_write, .range_value, .kiloamp_units, .shown_schedule, .base_write,
    .base_value, .data_up, .data_down, .enter_press, .offset_code, .cc_mode, .turns_ratio, .range_setting,
    .amp_gain, .percent_of_max, .cc_compensate, .cc_monitor, .shown_current, .display_value,
    .display_prefix, .display_offset_phase, .busy);
  front_panel_model u_panel (.ref_clk, .busy, .start, .press_dir, .press_count, .data_up, .data_down, .idle);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic check(input string name, input logic [CUR_W-1:0] expected, seen);
    compares++;
    if (seen !== expected)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, expected, seen);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
    for (int n = 0; n < 200 && busy !== 1'b0; n++)
      @(negedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1;
    check("busy", '0, busy);
  endtask
  task automatic setting(input int which, input logic [CUR_W-1:0] value);
    @(posedge ref_clk);
    code_value <= value[CODE_W-1:0];
    cc_value <= value[CODE_W-1:0];
    turns_value <= value[7:0];
    range_value <= value;
    base_value <= value;
    {code_write, cc_write, turns_write, range_write, base_write} <= 5'h10 >> which;
    @(posedge ref_clk);
    {code_write, cc_write, turns_write, range_write, base_write} <= '0;
    settle();
  endtask
  task automatic mode(input logic prog, input logic [SCHED_W-1:0] sched);
    @(posedge ref_clk);
    program_mode <= prog;
    shown_schedule <= sched;
    settle();
  endtask
  task automatic press(input logic dir, input logic [7:0] count);
    @(posedge ref_clk);
    start <= 1'h1;
    press_dir <= dir;
    press_count <= count;
    @(posedge ref_clk);
    start <= 1'h0;
    #1;
    for (int n = 0; n < 5000 && idle !== 1'b1; n++)
      @(negedge ref_clk);
    settle();
  endtask
  task automatic test_codes();
    setting(0, 14'h5);
    check("prefix", PREFIX_SINGLE, display_prefix);
    setting(0, 14'h2D);
    check("offset_code", 14'h5, offset_code);
    setting(0, 14'h19);
    check("prefix", PREFIX_ALL, display_prefix);
    setting(0, 14'h14);
    check("prefix", PREFIX_NONE, display_prefix);
  endtask
  task automatic test_range();
    setting(2, 14'h5);
    check("turns_ratio", 14'hA, turns_ratio);
    setting(2, 14'h14);
    setting(1, CC_PRESET_LO);
    check("flags", 14'h3, {cc_compensate, cc_monitor});
    setting(3, RANGE_MAX);
    check("range", 14'h190, range_setting);
    setting(3, 14'h64);
    check("range", RANGE_MIN, range_setting);
    setting(1, CC_PRESET_HI);
    setting(2, 14'hFF);
    setting(3, RANGE_MAX);
    check("range", RANGE_MAX, range_setting);
    check("flags", 14'h1, {cc_compensate, cc_monitor});
    setting(1, CC_SEC_COMP);
    setting(3, 14'h5DC);
    check("range", 14'h5DC, range_setting);
    check("amp_gain", 14'h1, amp_gain);
    setting(1, CC_AUTO_PRI_COMP);
    setting(3, RANGE_PERCENT);
    check("percent_of_max", 14'h1, percent_of_max);
    setting(1, CC_OFF);
    setting(3, 14'h1F4);
    check("range", 14'h0, range_setting);
  endtask
  task automatic bases(input logic [CUR_W-1:0] code);
    mode(1'h1, 6'h3);
    setting(0, code);
    setting(4, 14'h46);
    mode(1'h1, 6'h4);
    setting(4, 14'h28);
    mode(1'h0, 6'h3);
  endtask
  task automatic test_single();
    bases(14'h5);
    press(1'h1, 8'h8);
    check("shown_current", 14'h4B, shown_current);
    press(1'h0, 8'hC);
    check("shown_current", 14'h41, shown_current);
    check("cc_mode", CC_OFF, cc_mode);
    mode(1'h0, 6'h4);
    check("shown_current", 14'h28, shown_current);
  endtask
  task automatic test_all();
    bases(14'h19);
    press(1'h1, 8'h1);
    check("shown_current", 14'h47, shown_current);
    mode(1'h0, 6'h4);
    check("shown_current", 14'h29, shown_current);
    mode(1'h1, 6'h3);
    check("display_value", 14'h46, display_value);
    check("display_offset_phase", '0, display_offset_phase);
    check("shown_current", 14'h47, shown_current);
  endtask
  task automatic test_lock();
    bases(14'h0);
    press(1'h1, 8'h2);
    check("shown_current", 14'h46, shown_current);
    bases(14'h14);
    press(1'h0, 8'h2);
    check("shown_current", 14'h46, shown_current);
  endtask
  task automatic enter();
    @(posedge ref_clk);
    enter_press <= 1'h1;
    @(posedge ref_clk);
    enter_press <= 1'h0;
    settle();
  endtask
  task automatic test_kiloamp();
    mode(1'h1, 6'h3);
    @(posedge ref_clk);
    kiloamp_units <= 1'h1;
    setting(1, CC_SEC_COMP);
    setting(3, 14'h7D0);
    setting(0, 14'h5);
    setting(4, 14'h578);
    mode(1'h0, 6'h3);
    press(1'h1, 8'h3);
    check("shown_current", 14'h578, shown_current);
    check("display_value", 14'h57B, display_value);
    enter();
    check("shown_current", 14'h57B, shown_current);
    press(1'h1, 8'h96);
    enter();
    check("shown_current", 14'h5DC, shown_current);
  endtask
  task automatic stop_test();
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'h1;
    #1;
    check("offset_code", '0, offset_code);
    check("turns_ratio", 14'hA, turns_ratio);
    test_codes();
    test_range();
    test_single();
    test_all();
    test_lock();
    test_kiloamp();
    stop_test();
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    stop_test();
  end
endmodule
